// ===== verilog/tlds_defines.vh
// Contract
// - Polarity 0 drives the line high while the chosen source is true.
// - Polarity 1 drives the line low while the chosen source is true.
// - Source 0 disables the line; nothing drives it.
// - Source 1 asserts while an acquisition is in progress.
// - Source 2 asserts once the whole acquisition has completed.
// - Source 3 passes the pixel clock to the line.
// - Source 4 holds the line at its unasserted level per polarity.
// - Source 5 holds the line at its asserted level per polarity.
// - Source 6 asserts a line sync at the start of each camera line.
// - Source 7 asserts a frame sync per frame; not for line scan.
// - Source 8 asserts while a frame is being captured.
// - Source 9 asserts at the end of each captured frame.
// - Frame start and frame done are unsupported in line scan mode.
// - Source 10 pulses on scaled forward encoder movement.
// - Line type code: 0 external, 1 system bus line, 3 isolated output.
// - Line number selects the individual line within the chosen type.
// - The active edge is delayed from assertion by a programmable value.
// - Delay unit 4 counts scaled encoder ticks, 5 counts milliseconds.
// - On some variants non-zero delay needs each-buffer trigger action.
// - In line scan mode a programmable number of triggers is skipped.
// - Trigger action 3 makes each buffer wait for a trigger.
`ifndef TLDS_DEFINES_VH
`define TLDS_DEFINES_VH

// Register byte offsets
`define TLDS_REG_SEL 8'h00
`define TLDS_REG_CFG 8'h04
`define TLDS_REG_DLY 8'h08
`define TLDS_REG_SKIP 8'h0C
`define TLDS_REG_MODE 8'h10
`define TLDS_REG_STAT 8'h14

// Line select fields
`define TLDS_SEL_NUM_LSB 0
`define TLDS_SEL_TYPE_LSB 8

// Line type codes
`define TLDS_TYPE_EXT 2'h0
`define TLDS_TYPE_BUS 2'h1
`define TLDS_TYPE_ISO 2'h3

// Config fields
`define TLDS_CFG_SRC_LSB 0
`define TLDS_CFG_POL_BIT 4
`define TLDS_CFG_UNIT_LSB 8

// Drive sources
`define TLDS_SRC_OFF 4'h0
`define TLDS_SRC_ACQ 4'h1
`define TLDS_SRC_DONE 4'h2
`define TLDS_SRC_PCLK 4'h3
`define TLDS_SRC_UNASSERT 4'h4
`define TLDS_SRC_ASSERT 4'h5
`define TLDS_SRC_HSYNC 4'h6
`define TLDS_SRC_VSYNC 4'h7
`define TLDS_SRC_FSTART 4'h8
`define TLDS_SRC_FDONE 4'h9
`define TLDS_SRC_ENC 4'hA

// Delay units
`define TLDS_UNIT_ENC 3'h4
`define TLDS_UNIT_MS 3'h5

// Mode fields
`define TLDS_MODE_LSCAN_BIT 0
`define TLDS_MODE_ACT_LSB 4
`define TLDS_ACT_EACH_BUF 3'h3

// Reset values
`define TLDS_CFG_RESET 11'h000
`define TLDS_DLY_RESET 16'h0000
`define TLDS_SKIP_RESET 16'h0000

// Timing
`define TLDS_MS_NS 1000000
`define TLDS_CLK_NS 20
`define TLDS_MS_CYCLES (`TLDS_MS_NS / `TLDS_CLK_NS)

`endif

// ===== verilog/tlds_cfg_mem.v
`timescale 1ns/1ns
`include "tlds_defines.vh"

// Per-line configuration store with registered read port
module tlds_cfg_mem #(
    parameter AW = 3,
    parameter DW = 41
) (
    // Clock
    input wire clk_i,
    // Write port
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [DW-1:0] wr_data_i,
    // Read port
    input wire [AW-1:0] rd_addr_i,
    output reg [DW-1:0] rd_data_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Synchronous write and registered read
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

// ===== verilog/tlds_top.v
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ns
`include "tlds_defines.vh"

// Trigger line drive selector with Wishbone register access
module tlds_top #(
    parameter NUM_W = 2,
    parameter MS_CYCLES = `TLDS_MS_CYCLES,
    parameter STRICT_DELAY = 1'b1
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Acquisition status sources
    input wire acq_busy_i,
    input wire acq_done_i,
    input wire pix_clk_i,
    input wire line_sync_i,
    input wire frame_sync_i,
    input wire frame_busy_i,
    input wire frame_end_i,
    input wire enc_tick_i,
    // Trigger lines: external, system bus, isolated
    output reg [(1<<NUM_W)-1:0] ext_o,
    output reg [(1<<NUM_W)-1:0] ext_oe_o,
    output reg [(1<<NUM_W)-1:0] bus_o,
    output reg [(1<<NUM_W)-1:0] bus_oe_o,
    output reg [(1<<NUM_W)-1:0] iso_o,
    output reg [(1<<NUM_W)-1:0] iso_oe_o,
    // Line scan trigger after skipping
    output reg line_trig_o
);

    localparam NL = 1 << NUM_W;
    localparam NT = 3 * NL;
    localparam AW = NUM_W + 2;
    localparam DW = 41;
    localparam [31:0] MS_LIM = MS_CYCLES - 1;

    // Map a line type code and number to a flat line index
    function [AW-1:0] line_index;
        input [1:0] ltype;
        input [NUM_W-1:0] num;
        begin
            case (ltype)
                `TLDS_TYPE_EXT: line_index = {2'h0, num};
                `TLDS_TYPE_BUS: line_index = {2'h1, num};
                default: line_index = {2'h2, num};
            endcase
        end
    endfunction

    // Software-visible registers
    reg [1:0] sel_type_reg;
    reg [NUM_W-1:0] sel_num_reg;
    reg [10:0] cfg_reg [0:NT-1];
    reg [15:0] dly_reg [0:NT-1];
    reg [15:0] skip_reg;
    reg lscan_reg;
    reg [2:0] action_reg;
    reg dly_err_reg;

    wire [AW-1:0] cur = line_index(sel_type_reg, sel_num_reg);
    wire sel_valid = (sel_type_reg != 2'h2);
    wire wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

    // Copy of the data of every bus write with wb_sel_i[0] set, stored at the selected line's slot if the type is valid, for the memory module
    wire [DW-1:0] mem_rd;
    tlds_cfg_mem #(.AW(AW), .DW(DW)) u_mem (
        .clk_i(clk_i),
        .wr_en_i(wr_req & sel_valid),
        .wr_addr_i(cur),
        .wr_data_i({wb_dat_i[15:0], 14'h0000, wb_dat_i[10:0]}),
        .rd_addr_i(cur),
        .rd_data_o(mem_rd)
    );

    // Register writes; the config for the selected line only
    integer k;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_type_reg <= 2'h0;
            sel_num_reg <= {NUM_W{1'b0}};
            skip_reg <= `TLDS_SKIP_RESET;
            lscan_reg <= 1'b0;
            action_reg <= 3'h0;
            dly_err_reg <= 1'b0;
            for (k = 0; k < NT; k = k + 1) begin
                cfg_reg[k] <= `TLDS_CFG_RESET;
                dly_reg[k] <= `TLDS_DLY_RESET;
            end
        end else if (wr_req) begin
            case (wb_adr_i)
                `TLDS_REG_SEL: begin
                    sel_num_reg <= wb_dat_i[NUM_W-1:0];
                    sel_type_reg <= wb_dat_i[`TLDS_SEL_TYPE_LSB+1:`TLDS_SEL_TYPE_LSB];
                end
                `TLDS_REG_CFG: begin
                    if (sel_valid) begin
                        // Source, polarity and delay unit are all kept
                        cfg_reg[cur] <= wb_dat_i[10:0];
                    end
                end
                `TLDS_REG_DLY: begin
                    // Non-zero delay only with each-buffer action
                    if (STRICT_DELAY && wb_dat_i[15:0] != 16'h0000 &&
                        action_reg != `TLDS_ACT_EACH_BUF) begin
                        dly_err_reg <= 1'b1;
                    end else if (sel_valid) begin
                        dly_reg[cur] <= wb_dat_i[15:0];
                        dly_err_reg <= 1'b0;
                    end
                end
                `TLDS_REG_SKIP: skip_reg <= wb_dat_i[15:0];
                `TLDS_REG_MODE: begin
                    lscan_reg <= wb_dat_i[`TLDS_MODE_LSCAN_BIT];
                    action_reg <= wb_dat_i[`TLDS_MODE_ACT_LSB+2:`TLDS_MODE_ACT_LSB];
                end
                default: ;
            endcase
        end
    end

    // Wishbone answer: one wait state, unmapped reads return zero
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                `TLDS_REG_SEL: wb_dat_o <= {22'h000000, sel_type_reg,
                    {(8-NUM_W){1'b0}}, sel_num_reg};
                `TLDS_REG_CFG: wb_dat_o <= sel_valid ? {21'h000000, cfg_reg[cur]} : 32'h0;
                `TLDS_REG_DLY: wb_dat_o <= sel_valid ? {16'h0000, dly_reg[cur]} : 32'h0;
                `TLDS_REG_SKIP: wb_dat_o <= {16'h0000, skip_reg};
                `TLDS_REG_MODE: wb_dat_o <= {25'h0000000, action_reg, 3'h0, lscan_reg};
                `TLDS_REG_STAT: wb_dat_o <= {24'h000000, dly_err_reg, acq_busy_i,
                    acq_done_i, frame_busy_i, 3'h0, line_trig_o};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Shared millisecond tick
    reg [31:0] ms_cnt_reg;
    reg ms_tick_reg;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ms_cnt_reg <= 32'h00000000;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_tick_reg <= (ms_cnt_reg == MS_LIM);
            ms_cnt_reg <= (ms_cnt_reg == MS_LIM) ? 32'h00000000 : ms_cnt_reg + 32'h1;
        end
    end

    // Skip counter: in line scan pass one encoder tick, then ignore skip_reg ticks; otherwise pass every tick once any count left from line scan runs out
    reg [15:0] skip_cnt_reg;
    reg enc_scaled_reg;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            skip_cnt_reg <= 16'h0000;
            enc_scaled_reg <= 1'b0;
            line_trig_o <= 1'b0;
        end else begin
            enc_scaled_reg <= 1'b0;
            line_trig_o <= 1'b0;
            if (enc_tick_i) begin
                if (skip_cnt_reg == 16'h0000) begin
                    enc_scaled_reg <= 1'b1;
                    line_trig_o <= lscan_reg;
                    skip_cnt_reg <= lscan_reg ? skip_reg : 16'h0000;
                end else begin
                    skip_cnt_reg <= skip_cnt_reg - 16'h1;
                end
            end
        end
    end

    // Per-line source select, delay and pin drive
    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1) begin : g_line
            wire [3:0] src = cfg_reg[g][3:0];
            wire pol = cfg_reg[g][`TLDS_CFG_POL_BIT];
            wire [2:0] unit = cfg_reg[g][10:8];
            reg raw;
            reg act_reg;
            reg prev_reg;
            reg [15:0] dcnt_reg;

            // Source selection
            always @* begin
                case (src)
                    `TLDS_SRC_ACQ: raw = acq_busy_i;
                    `TLDS_SRC_DONE: raw = acq_done_i;
                    `TLDS_SRC_PCLK: raw = pix_clk_i;
                    `TLDS_SRC_UNASSERT: raw = 1'b0;
                    `TLDS_SRC_ASSERT: raw = 1'b1;
                    `TLDS_SRC_HSYNC: raw = line_sync_i;
                    `TLDS_SRC_VSYNC: raw = frame_sync_i & ~lscan_reg;
                    `TLDS_SRC_FSTART: raw = frame_busy_i & ~lscan_reg;
                    `TLDS_SRC_FDONE: raw = frame_end_i & ~lscan_reg;
                    `TLDS_SRC_ENC: raw = enc_scaled_reg;
                    default: raw = 1'b0;
                endcase
            end

            // Delay the active edge by dly_reg units
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    act_reg <= 1'b0;
                    prev_reg <= 1'b0;
                    dcnt_reg <= 16'h0000;
                end else begin
                    prev_reg <= raw;
                    if (!raw) begin
                        act_reg <= 1'b0;
                        dcnt_reg <= 16'h0000;
                    end else if (dly_reg[g] == 16'h0000) begin
                        act_reg <= 1'b1;
                    end else if (raw && !prev_reg) begin
                        dcnt_reg <= dly_reg[g];
                    end else if (!act_reg) begin
                        if (dcnt_reg == 16'h0000) begin
                            act_reg <= 1'b1;
                        end else if ((unit == `TLDS_UNIT_MS && ms_tick_reg) ||
                            (unit == `TLDS_UNIT_ENC && enc_scaled_reg)) begin
                            dcnt_reg <= dcnt_reg - 16'h1;
                        end
                    end
                end
            end

            // Pin drive with polarity
            wire lvl = act_reg ^ pol;
            wire en = (src != `TLDS_SRC_OFF) &&
                !(lscan_reg && (src == `TLDS_SRC_FSTART || src == `TLDS_SRC_FDONE));
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    if (g < NL) begin
                        ext_o[g] <= 1'b0;
                        ext_oe_o[g] <= 1'b0;
                    end else if (g < 2 * NL) begin
                        bus_o[g-NL] <= 1'b0;
                        bus_oe_o[g-NL] <= 1'b0;
                    end else begin
                        iso_o[g-2*NL] <= 1'b0;
                        iso_oe_o[g-2*NL] <= 1'b0;
                    end
                end else begin
                    if (g < NL) begin
                        ext_o[g] <= lvl;
                        ext_oe_o[g] <= en;
                    end else if (g < 2 * NL) begin
                        bus_o[g-NL] <= lvl;
                        bus_oe_o[g-NL] <= en;
                    end else begin
                        iso_o[g-2*NL] <= lvl;
                        iso_oe_o[g-2*NL] <= en;
                    end
                end
            end
        end
    endgenerate

endmodule

// ===== verification/tlds_monitor.sv
`timescale 1ns/1ns

// Watches the selector's bus handshake and trigger line pins
module tlds_monitor #(
    parameter NUM_W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Encoder tick and line scan trigger
    input wire logic enc_tick_i,
    input wire logic line_trig_o,
    // Trigger lines
    input wire logic [(1<<NUM_W)-1:0] ext_o,
    input wire logic [(1<<NUM_W)-1:0] ext_oe_o,
    input wire logic [(1<<NUM_W)-1:0] bus_o,
    input wire logic [(1<<NUM_W)-1:0] bus_oe_o,
    input wire logic [(1<<NUM_W)-1:0] iso_o,
    input wire logic [(1<<NUM_W)-1:0] iso_oe_o
);
    logic req;
    logic wrote_reg;
    logic [4:0] since_wr_reg;

    assign req = wb_cyc_i && wb_stb_i;

    // Remembers whether and how long ago software wrote anything
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wrote_reg <= 1'b0;
            since_wr_reg <= 5'h1F;
        end else if (req && wb_we_i) begin
            wrote_reg <= 1'b1;
            since_wr_reg <= 5'h00;
        end else if (since_wr_reg != 5'h1F) begin
            since_wr_reg <= since_wr_reg + 5'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Bus handshake
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property (!req |=> !wb_ack_o)
        else $error("ack without a request");
    a_unmapped_zero: assert property (req && !wb_we_i && !wb_ack_o && wb_adr_i > 8'h17
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // Trigger lines
    a_lines_idle_reset: assert property (!wrote_reg
        |-> {ext_oe_o, bus_oe_o, iso_oe_o, ext_o, bus_o, iso_o} == '0)
        else $error("line driven before any configuration");
    a_oe_after_write: assert property ($changed({ext_oe_o, bus_oe_o, iso_oe_o})
        |-> since_wr_reg < 5'd24) else $error("line enable changed without a write");
    a_trig_from_tick: assert property (line_trig_o
        |-> $past(enc_tick_i, 1) || $past(enc_tick_i, 2) || $past(enc_tick_i, 3))
        else $error("line trigger without an encoder tick");
    a_trig_needs_mode: assert property (line_trig_o |-> wrote_reg)
        else $error("line trigger before line scan was set");
endmodule

// ===== verification/tlds_trig_rx.sv
`timescale 1ns/1ns

// Far-side equipment: sees the wire level of every trigger line
module tlds_trig_rx (
    // Pins from the selector
    input wire logic clk_i,
    input wire logic [11:0] drv_i,
    input wire logic [11:0] oe_i,
    // Level seen on the wires
    output logic [11:0] wire_o
);
    logic [11:0] last_reg = 12'h000;

    // Undriven wires float away from their last level every cycle
    always_ff @(posedge clk_i) begin
        last_reg <= wire_o;
    end
    assign wire_o = (oe_i & drv_i) | (~oe_i & ~last_reg);
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`include "tlds_defines.vh"

// Register-level bench for the trigger line selector
module tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic [7:0] srcs = 8'h00;
    logic [3:0] ext_o, ext_oe_o, bus_o, bus_oe_o, iso_o, iso_oe_o;
    logic [11:0] lvl;
    logic [11:0] oes;
    logic ack;
    logic trig;
    int miscompares = 0;
    int comparisons = 0;
    int trigs = 0;
    int base;
    logic [3:0] codes [8] = '{`TLDS_SRC_ACQ, `TLDS_SRC_DONE, `TLDS_SRC_PCLK, `TLDS_SRC_HSYNC,
        `TLDS_SRC_VSYNC, `TLDS_SRC_FSTART, `TLDS_SRC_FDONE, `TLDS_SRC_ENC};
    logic [1:0] types [3] = '{`TLDS_TYPE_EXT, `TLDS_TYPE_BUS, `TLDS_TYPE_ISO};

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    tlds_top #(.NUM_W(2), .MS_CYCLES(5)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .acq_busy_i(srcs[0]), .acq_done_i(srcs[1]), .pix_clk_i(srcs[2]),
        .line_sync_i(srcs[3]), .frame_sync_i(srcs[4]), .frame_busy_i(srcs[5]),
        .frame_end_i(srcs[6]), .enc_tick_i(srcs[7]), .ext_o(ext_o), .ext_oe_o(ext_oe_o),
        .bus_o(bus_o), .bus_oe_o(bus_oe_o), .iso_o(iso_o), .iso_oe_o(iso_oe_o),
        .line_trig_o(trig));

    // Equipment on the far side of the lines
    assign oes = {iso_oe_o, bus_oe_o, ext_oe_o};
    tlds_trig_rx rx (.clk_i(clk_i), .drv_i({iso_o, bus_o, ext_o}), .oe_i(oes), .wire_o(lvl));

    // Counts line scan trigger pulses
    always @(posedge clk_i) begin
        if (trig === 1'b1) trigs <= trigs + 1;
    end

    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic bus cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // Waits a bounded time for the line to settle, then checks it
    task automatic see(input logic [1:0] ty, input int num, input logic oe, input logic lv);
        int b;
        int n;
        b = (ty == `TLDS_TYPE_ISO) ? 8 + num : ty * 4 + num;
        n = 0;
        // Let the last write reach the pins before trusting the level
        repeat (3) @(posedge clk_i);
        while (n < 40 && !(oes[b] === oe && (oe === 1'b0 || lvl[b] === lv))) begin
            @(posedge clk_i);
            n++;
        end
        chk("line enables", oe ? 32'(12'h1 << b) : 32'h0, 32'(oes));
        if (oe) chk("line level", 32'(lv), 32'(lvl[b]));
    endtask

    task automatic tick;
        srcs[7] <= 1'b1;
        @(posedge clk_i);
        srcs[7] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdchk("cfg", `TLDS_REG_CFG, 32'h0);
        rdchk("delay", `TLDS_REG_DLY, 32'h0);
        rdchk("skip", `TLDS_REG_SKIP, 32'h0);
        see(`TLDS_TYPE_EXT, 0, 1'b0, 1'b0);
        $display("reset test done");
        for (int t = 0; t < 3; t++) begin
            xfer(1'b1, `TLDS_REG_SEL, {22'h0, types[t], 6'h0, 2'(t + 1)});
            for (int p = 0; p < 2; p++) begin
                for (int s = 4; s < 6; s++) begin
                    xfer(1'b1, `TLDS_REG_CFG, {27'h0, 1'(p), 4'(s)});
                    rdchk("cfg", `TLDS_REG_CFG, {27'h0, 1'(p), 4'(s)});
                    see(types[t], t + 1, 1'b1, 1'((s == 5) ^ p));
                end
            end
            xfer(1'b1, `TLDS_REG_CFG, 32'h0);
            see(types[t], t + 1, 1'b0, 1'b0);
        end
        $display("forced level test done");
        xfer(1'b1, `TLDS_REG_SEL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            for (int p = 0; p < 2; p++) begin
                xfer(1'b1, `TLDS_REG_CFG, {27'h0, 1'(p), codes[i]});
                srcs <= 8'(1 << i);
                see(`TLDS_TYPE_EXT, 1, 1'b1, ~1'(p));
                srcs <= 8'h00;
                see(`TLDS_TYPE_EXT, 1, 1'b1, 1'(p));
            end
        end
        $display("source test done");
        xfer(1'b1, `TLDS_REG_MODE, 32'h1);
        xfer(1'b1, `TLDS_REG_SKIP, 32'h2);
        base = trigs;
        repeat (7) tick();
        chk("line scan triggers", 32'h3, 32'(trigs - base));
        xfer(1'b1, `TLDS_REG_MODE, 32'h0);
        base = trigs;
        repeat (3) tick();
        chk("area scan triggers", 32'h0, 32'(trigs - base));
        $display("skip test done");
        xfer(1'b1, `TLDS_REG_DLY, 32'h5);
        rdchk("refused delay", `TLDS_REG_DLY, 32'h0);
        xfer(1'b0, `TLDS_REG_STAT, 32'h0);
        chk("delay error", 32'h80, rd & 32'h80);
        xfer(1'b1, `TLDS_REG_MODE, 32'h30);
        xfer(1'b1, `TLDS_REG_DLY, 32'h5);
        rdchk("delay", `TLDS_REG_DLY, 32'h5);
        xfer(1'b1, `TLDS_REG_CFG, 32'h505);
        rdchk("cfg unit", `TLDS_REG_CFG, 32'h505);
        see(`TLDS_TYPE_EXT, 1, 1'b1, 1'b0);
        see(`TLDS_TYPE_EXT, 1, 1'b1, 1'b1);
        rdchk("unmapped", 8'h40, 32'h0);
        $display("delay test done");
        final_report();
    end
endmodule

bind tlds_top tlds_monitor #(.NUM_W(NUM_W)) mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_tick_i(enc_tick_i),
    .line_trig_o(line_trig_o), .ext_o(ext_o), .ext_oe_o(ext_oe_o), .bus_o(bus_o),
    .bus_oe_o(bus_oe_o), .iso_o(iso_o), .iso_oe_o(iso_oe_o));
